// File: rtl/core_state.sv
/*
 banked register file, status words, state and mode control, fetch halfword
 select and data lane mapping of the core.
 assumes decode drives at most one of the state changing operations a cycle;
 priority is exception entry, exception return, exchange branch, link branch.
*/
`timescale 1ns/1ps
module core_state
    import core_state_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_rd_a_idx,
    input wire logic [3:0] i_rd_b_idx,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_idx,
    input wire logic [31:0] i_wr_data,
    input wire logic i_pc_we,
    input wire logic [31:0] i_pc_value,
    input wire logic i_branch_exchange,
    input wire logic [31:0] i_exchange_operand,
    input wire logic i_branch_with_link,
    input wire logic [31:0] i_link_target,
    input wire logic i_exc_take,
    input wire logic [4:0] i_exc_mode,
    input wire logic [31:0] i_exc_vector,
    input wire logic i_exc_return,
    input wire logic [31:0] i_ret_addr,
    input wire logic i_status_we,
    input wire logic [31:0] i_status_data,
    input wire logic [31:0] i_fetch_word,
    input wire logic i_endian_big,
    input wire logic [1:0] i_mem_addr,
    input wire logic [1:0] i_mem_size,
    input wire logic [31:0] i_store_data,
    input wire logic [31:0] i_bus_rdata,
    output logic [31:0] o_rd_a_data,
    output logic [31:0] o_rd_b_data,
    output logic [31:0] o_pc,
    output logic [31:0] o_instr,
    output logic [31:0] o_current_status_word,
    output logic o_state_indicator_output,
    output logic o_privileged,
    output logic [31:0] o_bus_wdata,
    output logic [3:0] o_bus_be,
    output logic [31:0] o_load_data,
    output logic o_align_fault
);
    typedef struct packed {
        logic [NUM_GPR-1:0][31:0] gpr;
        logic [NUM_SAVED-1:0][31:0] saved;
        logic [31:0] cur;
        logic priv;
        logic [31:0] rd_a;
        logic [31:0] rd_b;
        logic [31:0] instr;
        logic [31:0] bus_wdata;
        logic [3:0] bus_be;
        logic [31:0] load_data;
        logic align_fault;
    } core_reg_t;

    core_reg_t st_r;
    core_reg_t st_nxt;
    logic [31:0] map_wdata;
    logic [3:0] map_be;
    logic [31:0] map_rdata;
    logic map_misaligned;

    function automatic logic mode_valid(input logic [4:0] m);
        mode_valid = (m == MODE_USER) || (m == MODE_FAST) || (m == MODE_IRQ) || (m == MODE_SUPER)
            || (m == MODE_ABORT) || (m == MODE_UNDEFINED) || (m == MODE_SYSTEM);
    endfunction

    function automatic logic has_saved(input logic [4:0] m);
        has_saved = mode_valid(m) && (m != MODE_USER) && (m != MODE_SYSTEM);
    endfunction

    function automatic logic [2:0] saved_idx(input logic [4:0] m);
        logic [2:0] s;
        s = SAVED_SUPER;
        unique case (m)
            MODE_FAST: s = SAVED_FAST;
            MODE_IRQ: s = SAVED_IRQ;
            MODE_ABORT: s = SAVED_ABORT;
            MODE_UNDEFINED: s = SAVED_UNDEFINED;
            default: s = SAVED_SUPER;
        endcase
        return s;
    endfunction

    // physical slot of a visible register; compact sp and lr use r13 and r14 here
    function automatic logic [4:0] bank_idx(input logic [4:0] m, input logic [3:0] r);
        logic [4:0] b;
        b = {1'b0, r};
        if (r == REG_PC)
            b = PHYS_PC;
        else if ((m == MODE_FAST) && (r >= 4'h8))
            b = FAST_BASE + {1'b0, r} - 5'h08;
        else if (r >= 4'hD)
        begin
            unique case (m)
                MODE_IRQ: b = IRQ_BASE + {4'h0, ~r[0]};
                MODE_SUPER: b = SUPER_BASE + {4'h0, ~r[0]};
                MODE_ABORT: b = ABORT_BASE + {4'h0, ~r[0]};
                MODE_UNDEFINED: b = UNDEFINED_BASE + {4'h0, ~r[0]};
                default: b = {1'b0, r};
            endcase
        end
        return b;
    endfunction

    function automatic logic [31:0] align_pc(input logic [31:0] a, input logic compact);
        align_pc = compact ? {a[31:1], 1'b0} : {a[31:2], 2'b00};
    endfunction

    byte_lane_map u_lanes (
        .i_big(i_endian_big),
        .i_addr(i_mem_addr),
        .i_size(i_mem_size),
        .i_wdata(i_store_data),
        .i_rdata(i_bus_rdata),
        .o_wdata(map_wdata),
        .o_be(map_be),
        .o_rdata(map_rdata),
        .o_misaligned(map_misaligned)
    );

    always_comb
    begin
        logic [4:0] mode;
        logic compact;
        logic [31:0] pc;
        logic [31:0] restored;
        logic half_hi;
        mode = st_r.cur[ST_MODE_LSB +: 5];
        compact = st_r.cur[ST_COMPACT];
        pc = st_r.gpr[PHYS_PC];
        restored = st_r.saved[saved_idx(mode)];
        half_hi = i_endian_big ? ~pc[1] : pc[1];
        st_nxt = st_r;
        if (i_exc_take && has_saved(i_exc_mode))
        begin
            st_nxt.saved[saved_idx(i_exc_mode)] = st_r.cur;
            st_nxt.gpr[bank_idx(i_exc_mode, REG_LINK)] = pc;
            st_nxt.cur[ST_MODE_LSB +: 5] = i_exc_mode;
            st_nxt.cur[ST_COMPACT] = 1'b0;
            st_nxt.cur[ST_IRQ_OFF] = 1'b1;
            if (i_exc_mode == MODE_FAST)
                st_nxt.cur[ST_FAST_OFF] = 1'b1;
            st_nxt.gpr[PHYS_PC] = align_pc(i_exc_vector, 1'b0);
        end
        else if (i_exc_return && has_saved(mode))
        begin
            st_nxt.cur = restored;
            st_nxt.gpr[PHYS_PC] = align_pc(i_ret_addr, restored[ST_COMPACT]);
        end
        else if (i_branch_exchange)
        begin
            st_nxt.cur[ST_COMPACT] = i_exchange_operand[0];
            st_nxt.gpr[PHYS_PC] = align_pc(i_exchange_operand, i_exchange_operand[0]);
        end
        else if (i_branch_with_link)
        begin
            st_nxt.gpr[bank_idx(mode, REG_LINK)] = pc;
            st_nxt.gpr[PHYS_PC] = align_pc(i_link_target, compact);
        end
        else
        begin
            if (i_status_we)
            begin
                st_nxt.cur[31:ST_FLAG_LSB] = i_status_data[31:ST_FLAG_LSB];
                if (st_r.priv && mode_valid(i_status_data[ST_MODE_LSB +: 5]))
                begin
                    st_nxt.cur[ST_IRQ_OFF] = i_status_data[ST_IRQ_OFF];
                    st_nxt.cur[ST_FAST_OFF] = i_status_data[ST_FAST_OFF];
                    st_nxt.cur[ST_MODE_LSB +: 5] = i_status_data[ST_MODE_LSB +: 5];
                end
            end
            if (i_pc_we)
                st_nxt.gpr[PHYS_PC] = align_pc(i_pc_value, compact);
            if (i_wr_en)
            begin
                if (i_wr_idx == REG_PC)
                    st_nxt.gpr[PHYS_PC] = align_pc(i_wr_data, compact);
                else
                    st_nxt.gpr[bank_idx(mode, i_wr_idx)] = i_wr_data;
            end
        end
        st_nxt.priv = st_nxt.cur[ST_MODE_LSB +: 5] != MODE_USER;
        st_nxt.rd_a = st_r.gpr[bank_idx(mode, i_rd_a_idx)];
        st_nxt.rd_b = st_r.gpr[bank_idx(mode, i_rd_b_idx)];
        if (compact)
            st_nxt.instr = {16'h0000, half_hi ? i_fetch_word[31:16] : i_fetch_word[15:0]};
        else
            st_nxt.instr = i_fetch_word;
        st_nxt.bus_wdata = map_wdata;
        st_nxt.bus_be = map_be;
        st_nxt.load_data = map_rdata;
        st_nxt.align_fault = map_misaligned;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= '0;
            st_r.cur <= RESET_STATUS;
            st_r.gpr[PHYS_PC] <= RESET_VECTOR;
            st_r.priv <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_rd_a_data = st_r.rd_a;
    assign o_rd_b_data = st_r.rd_b;
    assign o_pc = st_r.gpr[PHYS_PC];
    assign o_instr = st_r.instr;
    assign o_current_status_word = st_r.cur;
    assign o_state_indicator_output = st_r.cur[ST_COMPACT];
    assign o_privileged = st_r.priv;
    assign o_bus_wdata = st_r.bus_wdata;
    assign o_bus_be = st_r.bus_be;
    assign o_load_data = st_r.load_data;
    assign o_align_fault = st_r.align_fault;

    a_exchange_state_pick: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_branch_exchange && !i_exc_take && !i_exc_return)
        |=> (o_state_indicator_output == $past(i_exchange_operand[0])) && (o_pc[0] == 1'b0))
        else $error("exchange branch picked wrong state");

    a_switch_keeps_mode: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_branch_exchange && !i_exc_take && !i_exc_return)
        |=> $stable(o_current_status_word[ST_MODE_LSB +: 5]) && $stable(st_r.gpr[14:0]))
        else $error("state switch changed mode or registers");

    a_exc_entry_wide: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_exc_take && has_saved(i_exc_mode))
        |=> !o_state_indicator_output && (o_pc == {$past(i_exc_vector[31:2]), 2'b00})
        && (st_r.gpr[bank_idx($past(i_exc_mode), REG_LINK)] == $past(o_pc)))
        else $error("exception entry did not link and vector in wide state");

    a_exc_return_state: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_exc_return && !i_exc_take && has_saved(o_current_status_word[4:0]))
        |=> (o_state_indicator_output == $past(st_r.saved[saved_idx(o_current_status_word[4:0])][ST_COMPACT])))
        else $error("exception return lost compact state");

    a_pc_low_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        o_state_indicator_output ? (o_pc[0] == 1'b0) : (o_pc[1:0] == 2'b00))
        else $error("pc low bits not zero");

    a_mode_code_legal: assert property (@(posedge i_clk) disable iff (i_rst)
        mode_valid(o_current_status_word[ST_MODE_LSB +: 5]))
        else $error("illegal mode code held");

    a_fast_bank_private: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr_en && (i_wr_idx == 4'h8) && (o_current_status_word[4:0] == MODE_FAST)
        && !i_exc_take && !i_exc_return && !i_branch_exchange && !i_branch_with_link)
        |=> $stable(st_r.gpr[8]) && (st_r.gpr[FAST_BASE] == $past(i_wr_data)))
        else $error("fast mode wrote the shared r8");

    a_link_copy_pc: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_branch_with_link && !i_exc_take && !i_exc_return && !i_branch_exchange)
        ##1 (i_rd_a_idx == REG_LINK) && $stable(o_current_status_word[4:0])
        |=> o_rd_a_data == $past(o_pc, 2))
        else $error("link register did not receive pc");

    a_big_byte_lane: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_endian_big && (i_mem_size == SIZE_BYTE) && (i_mem_addr == 2'h0))
        |=> (o_bus_be == 4'h8) && (o_load_data[7:0] == $past(i_bus_rdata[31:24])))
        else $error("big endian byte 0 not on top lane");

    a_little_byte_lane: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_endian_big && (i_mem_size == SIZE_BYTE) && (i_mem_addr == 2'h0))
        |=> (o_bus_be == 4'h1) && (o_load_data[7:0] == $past(i_bus_rdata[7:0])))
        else $error("little endian byte 0 not on bottom lane");

    a_compact_half_pick: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_state_indicator_output && !i_endian_big && o_pc[1])
        |=> o_instr == {16'h0000, $past(i_fetch_word[31:16])})
        else $error("compact fetch picked wrong halfword");

    a_user_not_priv: assert property (@(posedge i_clk) disable iff (i_rst)
        o_privileged == (o_current_status_word[4:0] != MODE_USER))
        else $error("privilege flag disagrees with mode");

    a_reset_wide_super: assert property (@(posedge i_clk)
        i_rst |-> (o_current_status_word == RESET_STATUS) && (o_pc == RESET_VECTOR) && o_privileged)
        else $error("reset state not wide supervisor");

    a_entry_saves_word: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_exc_take && has_saved(i_exc_mode))
        |=> st_r.saved[saved_idx($past(i_exc_mode))] == $past(o_current_status_word))
        else $error("exception entry lost the old status word");

    a_entry_sets_mode: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_exc_take && has_saved(i_exc_mode))
        |=> (o_current_status_word[4:0] == $past(i_exc_mode)) && o_privileged)
        else $error("exception entry mode wrong");

    a_wide_full_word: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_state_indicator_output
        |=> o_instr == $past(i_fetch_word))
        else $error("wide fetch not a full word");

    a_compact_half_width: assert property (@(posedge i_clk) disable iff (i_rst)
        o_state_indicator_output
        |=> o_instr[31:16] == 16'h0000)
        else $error("compact instruction wider than a halfword");

    a_big_half_pick: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_state_indicator_output && i_endian_big && !o_pc[1])
        |=> o_instr == {16'h0000, $past(i_fetch_word[31:16])})
        else $error("big endian compact fetch picked wrong halfword");

    a_super_bank_private: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr_en && (i_wr_idx == 4'hD) && (o_current_status_word[4:0] == MODE_SUPER)
        && !i_exc_take && !i_exc_return && !i_branch_exchange && !i_branch_with_link)
        |=> $stable(st_r.gpr[13]) && (st_r.gpr[SUPER_BASE] == $past(i_wr_data)))
        else $error("supervisor mode wrote the shared r13");

    a_pc_load_value: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_pc_we && !i_wr_en && !i_exc_take && !i_exc_return && !i_branch_exchange && !i_branch_with_link)
        |=> o_pc[31:2] == $past(i_pc_value[31:2]))
        else $error("pc load lost address bits");

    a_link_keeps_status: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_branch_with_link && !i_exc_take && !i_exc_return && !i_branch_exchange)
        |=> $stable(o_current_status_word) && (o_pc[31:2] == $past(i_link_target[31:2])))
        else $error("link branch changed status or missed target");

    a_word_align_fault: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_mem_size == SIZE_WORD)
        |=> (o_align_fault == $past(|i_mem_addr)) && (o_bus_be == 4'hF))
        else $error("word access fault or lanes wrong");

    a_user_control_locked: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_status_we && !o_privileged && !i_exc_take && !i_exc_return && !i_branch_exchange && !i_branch_with_link)
        |=> $stable(o_current_status_word[7:0]))
        else $error("user mode changed control bits");

    a_illegal_mode_kept: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_status_we && !mode_valid(i_status_data[4:0]) && !i_exc_take && !i_exc_return && !i_branch_exchange
        && !i_branch_with_link) |=> $stable(o_current_status_word[7:0]))
        else $error("illegal mode code accepted");

    a_status_keeps_state: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_status_we && !i_exc_take && !i_exc_return && !i_branch_exchange && !i_branch_with_link)
        |=> $stable(o_state_indicator_output))
        else $error("status write changed the state bit");
endmodule

// File: rtl/core_state_pkg.sv
/*
 holds the constants, mode codes and field positions of the core state block.
 assumes one core clock and that the decode logic drives one operation a cycle.
*/
// Operation
// - compact state picks halfword by pc bit 1
// - state switch keeps mode and registers
// - exchange branch operand bit 0 picks state
// - exception return restores compact state
// - exception enters wide state, links, vectors
// - big endian puts byte 0 on 31:24
// - little endian puts byte 0 on 7:0
// - endian follows coprocessor control bit
// - instruction width 32 wide, 16 compact
// - 31 general plus six status registers
// - sixteen visible registers, banks in privileged modes; system mode uses the unbanked user registers
// - branch with link copies r15 into r14
// - pc low bits read zero per state
// - fast mode banks r8 to r14
// - other exception modes bank r13, r14
// - status word holds flags and mode
// - mode changes by software or exceptions
// - seven legal five-bit mode codes
// - state bit shown on indicator output
// - compact sp, lr map to r13, r14
package core_state_pkg;
    localparam int NUM_GPR = 31;
    localparam int NUM_SAVED = 5;
    localparam logic [4:0] MODE_USER = 5'h10;
    localparam logic [4:0] MODE_FAST = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SUPER = 5'h13;
    localparam logic [4:0] MODE_ABORT = 5'h17;
    localparam logic [4:0] MODE_UNDEFINED = 5'h1B;
    localparam logic [4:0] MODE_SYSTEM = 5'h1F;
    localparam logic [4:0] PHYS_PC = 5'h1E;
    localparam logic [4:0] FAST_BASE = 5'h0F;
    localparam logic [4:0] IRQ_BASE = 5'h16;
    localparam logic [4:0] SUPER_BASE = 5'h18;
    localparam logic [4:0] ABORT_BASE = 5'h1A;
    localparam logic [4:0] UNDEFINED_BASE = 5'h1C;
    localparam logic [2:0] SAVED_FAST = 3'h0;
    localparam logic [2:0] SAVED_IRQ = 3'h1;
    localparam logic [2:0] SAVED_SUPER = 3'h2;
    localparam logic [2:0] SAVED_ABORT = 3'h3;
    localparam logic [2:0] SAVED_UNDEFINED = 3'h4;
    localparam int ST_FLAG_LSB = 28;
    localparam int ST_IRQ_OFF = 7;
    localparam int ST_FAST_OFF = 6;
    localparam int ST_COMPACT = 5;
    localparam int ST_MODE_LSB = 0;
    localparam logic [3:0] REG_LINK = 4'hE;
    localparam logic [3:0] REG_PC = 4'hF;
    localparam logic [31:0] RESET_STATUS = 32'h000000D3;
    localparam logic [31:0] RESET_VECTOR = 32'h00000000;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
endpackage

// File: rtl/byte_lane_map.sv
/*
 maps byte, halfword and word accesses onto the four lanes of the data bus.
 assumes a 32-bit bus and an endian select from the system control coprocessor.
*/
`timescale 1ns/1ps
module byte_lane_map
    import core_state_pkg::*;
(
    input wire logic i_big,
    input wire logic [1:0] i_addr,
    input wire logic [1:0] i_size,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] i_rdata,
    output logic [31:0] o_wdata,
    output logic [3:0] o_be,
    output logic [31:0] o_rdata,
    output logic o_misaligned
);
    logic [1:0] lane;
    logic [31:0] shifted;
    always_comb
    begin
        lane = i_big ? ~i_addr : i_addr;
        shifted = i_rdata >> {lane, 3'b000};
        o_wdata = i_wdata;
        o_be = 4'hF;
        o_rdata = i_rdata;
        o_misaligned = 1'b0;
        if (i_size == SIZE_BYTE)
        begin
            o_wdata = {4{i_wdata[7:0]}};
            o_be = 4'h1 << lane;
            o_rdata = {24'h000000, shifted[7:0]};
        end
        else if (i_size == SIZE_HALF)
        begin
            lane = {lane[1], 1'b0};
            shifted = i_rdata >> {lane, 3'b000};
            o_wdata = {2{i_wdata[15:0]}};
            o_be = lane[1] ? 4'hC : 4'h3;
            o_rdata = {16'h0000, shifted[15:0]};
            o_misaligned = i_addr[0];
        end
        else
        begin
            o_misaligned = |i_addr;
        end
    end
endmodule

// File: sim/memory_side_model.sv
/*
 behavioural memory system on the far side of the core state block.
 assumes fetches of whole aligned words and a fixed data word on loads.
*/
`timescale 1ns/1ps
module memory_side_model
    import core_state_pkg::*;
#(
    parameter logic [31:0] DATA_WORD = 32'h88442211
)
(
    input wire logic [31:0] i_pc,
    output logic [31:0] o_fetch_word,
    output logic [31:0] o_rdata
);
    always_comb
    begin
        o_fetch_word = {~i_pc[15:0], i_pc[15:0]};
        o_rdata = DATA_WORD;
    end
endmodule

// File: sim/test_cpu_state_mode_register_banking.sv
/*
 self-checking bench of the core state block with its memory model.
 assumes every output is registered one cycle after its operation.
*/
`timescale 1ns/1ps
module test_cpu_state_mode_register_banking;
    import core_state_pkg::*;
    localparam logic [31:0] DATA_WORD = 32'h88442211;
    logic i_clk, i_rst, i_wr_en, i_pc_we, i_branch_exchange, i_branch_with_link;
    logic i_exc_take, i_exc_return, i_status_we, i_endian_big;
    logic [3:0] i_rd_a_idx, i_rd_b_idx, i_wr_idx, o_bus_be;
    logic [4:0] i_exc_mode;
    logic [1:0] i_mem_addr, i_mem_size;
    logic [31:0] i_wr_data, i_pc_value, i_exchange_operand, i_link_target, i_exc_vector, i_ret_addr;
    logic [31:0] i_status_data, i_fetch_word, i_store_data, i_bus_rdata, o_bus_wdata, o_load_data;
    logic [31:0] o_rd_a_data, o_rd_b_data, o_pc, o_instr, o_current_status_word;
    logic o_state_indicator_output, o_privileged, o_align_fault;
    logic [4:0] exc_modes [5] = '{MODE_FAST, MODE_IRQ, MODE_SUPER, MODE_ABORT, MODE_UNDEFINED};
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    core_state i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_rd_a_idx(i_rd_a_idx), .i_rd_b_idx(i_rd_b_idx),
        .i_wr_en(i_wr_en), .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data), .i_pc_we(i_pc_we),
        .i_pc_value(i_pc_value), .i_branch_exchange(i_branch_exchange), .i_exchange_operand(i_exchange_operand),
        .i_branch_with_link(i_branch_with_link), .i_link_target(i_link_target), .i_exc_take(i_exc_take),
        .i_exc_mode(i_exc_mode), .i_exc_vector(i_exc_vector), .i_exc_return(i_exc_return),
        .i_ret_addr(i_ret_addr), .i_status_we(i_status_we), .i_status_data(i_status_data),
        .i_fetch_word(i_fetch_word), .i_endian_big(i_endian_big), .i_mem_addr(i_mem_addr),
        .i_mem_size(i_mem_size), .i_store_data(i_store_data), .i_bus_rdata(i_bus_rdata),
        .o_rd_a_data(o_rd_a_data), .o_rd_b_data(o_rd_b_data), .o_pc(o_pc), .o_instr(o_instr),
        .o_current_status_word(o_current_status_word), .o_state_indicator_output(o_state_indicator_output),
        .o_privileged(o_privileged), .o_bus_wdata(o_bus_wdata), .o_bus_be(o_bus_be),
        .o_load_data(o_load_data), .o_align_fault(o_align_fault)
    );

    memory_side_model #(.DATA_WORD(DATA_WORD)) i_mem (
        .i_pc(o_pc), .o_fetch_word(i_fetch_word), .o_rdata(i_bus_rdata)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic test_done();
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(negedge i_clk);
    endtask

    // one-cycle strobe, then an idle cycle so no strobe is set twice in a step
    task automatic pulse();
        tick();
        {i_wr_en, i_pc_we, i_branch_exchange, i_branch_with_link, i_exc_take, i_exc_return, i_status_we} = 7'h0;
        tick();
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        {i_wr_en, i_wr_idx, i_wr_data} = {1'b1, idx, d};
        pulse();
    endtask

    task automatic setst(input logic [31:0] d);
        {i_status_we, i_status_data} = {1'b1, d};
        pulse();
    endtask

    task automatic exch(input logic [31:0] v);
        {i_branch_exchange, i_exchange_operand} = {1'b1, v};
        pulse();
    endtask

    task automatic pcw(input logic [31:0] v);
        {i_pc_we, i_pc_value} = {1'b1, v};
        pulse();
    endtask

    task automatic exc(input logic [4:0] m, input logic [31:0] v);
        {i_exc_take, i_exc_mode, i_exc_vector} = {1'b1, m, v};
        pulse();
    endtask

    task automatic ret(input logic [31:0] v);
        {i_exc_return, i_ret_addr} = {1'b1, v};
        pulse();
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        i_rd_a_idx = idx;
        i_rd_b_idx = idx;
        tick();
        check(o_rd_a_data, exp);
        check(o_rd_b_data, exp);
    endtask

    task automatic lane(input int e, input int s, input int a);
        int n;
        int ln;
        logic [31:0] m;
        n = 1 << s;
        ln = (e != 0) ? 4 - n - a : a;
        i_endian_big = e[0];
        i_mem_size = s[1:0];
        i_mem_addr = a[1:0];
        i_store_data = 32'hCAFEF00D;
        tick();
        check({31'h0, o_align_fault}, {31'h0, (a % n) != 0});
        if ((a % n) == 0)
        begin
            m = 32'(((64'h1 << (8 * n)) - 64'h1) << (8 * ln));
            check({28'h0, o_bus_be}, 32'(((1 << n) - 1) << ln));
            check(o_bus_wdata & m, (32'hCAFEF00D << (8 * ln)) & m);
            check(o_load_data, (DATA_WORD & m) >> (8 * ln));
        end
    endtask

    initial
    begin
        {i_rst, i_wr_en, i_pc_we, i_branch_exchange, i_branch_with_link, i_exc_take} = 6'h20;
        {i_exc_return, i_status_we, i_endian_big, i_rd_a_idx, i_rd_b_idx, i_wr_idx, i_exc_mode} = 20'h0;
        {i_mem_addr, i_mem_size, i_wr_data, i_pc_value, i_exchange_operand, i_link_target} = 132'h0;
        {i_exc_vector, i_ret_addr, i_status_data, i_store_data} = 128'h0;
        repeat (20) tick();
        i_rst = 1'b0;
        check(o_current_status_word, RESET_STATUS);
        check(o_pc, RESET_VECTOR);
        check({31'h0, o_privileged}, 32'h1);
        check({31'h0, o_state_indicator_output}, 32'h0);
        tick();
        check(o_instr, 32'hFFFF0000);
        for (int i = 0; i < 15; i++)
            wr(4'(i), 32'h10000000 + 32'(i));
        setst(32'h000000D1);
        check(o_current_status_word, 32'h000000D1);
        for (int i = 8; i < 15; i++)
            wr(4'(i), 32'h20000000 + 32'(i));
        setst(32'h000000DF);
        for (int i = 0; i < 15; i++)
            rd(4'(i), (i < 13) ? 32'h10000000 + 32'(i) : 32'h0);
        setst(32'h000000D1);
        for (int i = 8; i < 15; i++)
            rd(4'(i), 32'h20000000 + 32'(i));
        setst(32'h000000D2);
        rd(4'hD, 32'h0);
        rd(4'h8, 32'h10000008);
        setst(32'h000000D3);
        setst(32'hF00000D5);
        check(o_current_status_word, 32'hF00000D3);
        setst(32'h000000D3);
        exch(32'h00000101);
        check(o_current_status_word, 32'h000000F3);
        check({31'h0, o_state_indicator_output}, 32'h1);
        check(o_pc, 32'h00000100);
        check(o_instr, 32'h00000100);
        rd(4'h0, 32'h10000000);
        rd(4'hD, 32'h1000000D);
        i_endian_big = 1'b1;
        tick();
        check(o_instr, 32'h0000FEFF);
        i_endian_big = 1'b0;
        pcw(32'h00000207);
        check(o_pc, 32'h00000206);
        check(o_instr, 32'h0000FDF9);
        exch(32'h00000204);
        check(o_current_status_word, 32'h000000D3);
        pcw(32'h00000207);
        check(o_pc, 32'h00000204);
        check(o_instr, 32'hFDFB0204);
        i_rd_a_idx = 4'hE;
        {i_branch_with_link, i_link_target} = {1'b1, 32'h00000300};
        pulse();
        check(o_pc, 32'h00000300);
        rd(4'hE, 32'h00000204);
        for (int k = 0; k < 5; k++)
        begin
            exc(exc_modes[k], 32'h0000001C);
            check(o_pc, 32'h0000001C);
            check(o_current_status_word, {24'h0, 3'h6, exc_modes[k]});
            rd(4'hE, 32'h00000300);
            ret(32'h00000300);
            check(o_current_status_word, 32'h000000D3);
        end
        exch(32'h00000401);
        exc(MODE_IRQ, 32'h00000018);
        check(o_current_status_word, 32'h000000D2);
        check(o_pc, 32'h00000018);
        rd(4'hE, 32'h00000400);
        ret(32'h00000402);
        check(o_current_status_word, 32'h000000F3);
        check(o_pc, 32'h00000402);
        for (int e = 0; e < 2; e++)
            for (int s = 0; s < 3; s++)
                for (int a = 0; a < 4; a++)
                    lane(e, s, a);
        setst(32'h00000010);
        check(o_current_status_word, 32'h00000030);
        check({31'h0, o_privileged}, 32'h0);
        setst(32'h000000D3);
        check(o_current_status_word, 32'h00000030);
        test_done();
    end
endmodule
